// >>> src/sps_pkg.sv
// Summary of operation
// - Deep sleep stops CPU, peripheral, oscillator clocks
// - Clock monitor off in sleep; RC runs for watchdog
// - Brown-out and voltage detect stay on
// - Sleep exit: interrupt, any reset, watchdog
// - Wake restarts prior clock, current select
// - Power-on/brown-out picks configured oscillator
// - Crystal waits start-up timer, PLL lock, delays
// - RC or external clock waits power-on delay only
// - Low-power crystal kept running: power-on delay only
// - Interrupt wake from sleep vectors, sets sleep flag
// - Clock still dead: trap if monitor, else wait
// - Reset ends sleep; non-power-on sets sleep flag
// - Watchdog wake from sleep sets sleep, timeout flags
// - Idle stops the CPU clock, not the oscillator
// - Per-module idle bit halts peripherals in idle
// - Idle keeps RC running when monitor enabled
// - Idle exit: interrupt, any reset, watchdog
// - Idle exit resumes at once, no delay
// - Interrupt wake from idle vectors, sets idle flag
// - Non-power-on reset sets idle flag; power-on clears
// - Watchdog wake from idle sets idle, timeout flags
// - Config words 24 bits, data in low 16
// - One power-save instruction picks idle or sleep
package sps_pkg;
	// Configuration word addresses
	localparam logic [23:0] SPS_ADDR_OSC_CFG = 24'hF80000;
	localparam logic [23:0] SPS_ADDR_WDT_CFG = 24'hF80002;
	localparam logic [23:0] SPS_ADDR_BOR_CFG = 24'hF80004;
	localparam logic [23:0] SPS_ADDR_CSP_CFG = 24'hF8000A;
	// Oscillator configuration field positions
	localparam int SPS_FOS_LSB = 8;
	localparam int SPS_FPR_LSB = 0;
	// Oscillator families (current select / family field)
	localparam logic [1:0] SPS_OSC_LOW_POWER_RC_OSC = 2'h0;
	localparam logic [1:0] SPS_OSC_FRC = 2'h1;
	localparam logic [1:0] SPS_OSC_LP = 2'h2;
	localparam logic [1:0] SPS_OSC_PRI = 2'h3;
	// Power-on delay in ns and clock period
	localparam int SPS_CLK_PERIOD_NS = 40;
	localparam int SPS_POWER_ON_DELAY_NS = 10000;
	localparam int SPS_POWER_ON_DELAY_CYC = SPS_POWER_ON_DELAY_NS / SPS_CLK_PERIOD_NS;
	localparam int SPS_CNT_W = 16;
	// Reset values
	localparam logic [1:0] SPS_COSC_RST = 2'h1;
	// Power-save instruction operand
	localparam logic SPS_OP_SLEEP = 1'b0;
	localparam logic SPS_OP_IDLE = 1'b1;
	// Controller states
	typedef enum logic [4:0] {
		SPS_RUN = 5'h01,
		SPS_IDLE = 5'h02,
		SPS_SLEEP = 5'h04,
		SPS_WAKE_DLY = 5'h08,
		SPS_WAKE_OSC = 5'h10
	} sps_state_t;
endpackage

// >>> src/sps_ctrl.sv
`timescale 1ns/1ps
module sps_ctrl
	import sps_pkg::*;
#(
	parameter int PERIPH_N = 8,
	parameter int POWER_UP_TIMER_CYC = 1600,
	parameter int LOCK_CYC = 50
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Reset causes, one-cycle pulses
	input wire logic por_pulse,
	input wire logic bor_pulse,
	input wire logic master_clear_reset_pulse,
	// Power-save instruction from the CPU
	input wire logic power_save_instruction_valid,
	input wire logic power_save_instruction_operand,
	// Wake events
	input wire logic irq_pending,
	input wire logic wdt_timeout,
	// Static enables
	input wire logic wdt_enable,
	input wire logic fail_safe_clock_monitor_enable,
	input wire logic bor_enable,
	input wire logic lvd_enable,
	input wire logic clk_switch_enable,
	input wire logic lp_osc_keep_on,
	input wire logic [1:0] current_osc_select,
	input wire logic [PERIPH_N-1:0] periph_idle_stop,
	// Oscillator block status
	input wire logic osc_startup_done,
	input wire logic pll_enable,
	input wire logic pll_locked,
	input wire logic osc_running,
	// Configuration word read port
	input wire logic [23:0] cfg_addr,
	input wire logic [15:0] osc_cfg_word,
	input wire logic [15:0] wdt_cfg_word,
	input wire logic [15:0] bor_cfg_word,
	input wire logic [15:0] csp_cfg_word,
	output logic [23:0] cfg_rdata,
	// Clock gates
	output logic cpu_clk_en,
	output logic [PERIPH_N-1:0] periph_clk_en,
	output logic osc_en,
	output logic low_power_rc_osc_en,
	output logic fail_safe_clock_monitor_active,
	output logic bor_active,
	output logic lvd_active,
	output logic [1:0] wake_osc_sel,
	output logic ost_start,
	// CPU control
	output logic cpu_vector_irq,
	output logic clk_fail_trap,
	output logic frc_force,
	// Status flags
	output logic sleep_flag,
	output logic idle_flag,
	output logic watchdog_timeout_flag_flag
);

	typedef struct packed {
		sps_state_t st;
		logic [SPS_CNT_W-1:0] cnt;
		logic need_osc;
		logic irq_wake;
		logic [1:0] osc;
		logic sleep_f;
		logic idle_f;
		logic watchdog_timeout_flag_f;
		logic vec;
		logic trap;
		logic fast_rc_osc;
		logic osc_startup_timer;
		logic [23:0] rdata;
	} sps_regs_t;

	sps_regs_t q_r;
	sps_regs_t q_nxt;
	logic any_reset;
	logic pwr_reset;
	logic [1:0] cfg_osc;

	assign any_reset = por_pulse | bor_pulse | master_clear_reset_pulse;
	assign pwr_reset = por_pulse | bor_pulse;
	assign cfg_osc = osc_cfg_word[SPS_FOS_LSB +: 2];

	// Next-state logic
	always_comb
	begin
		q_nxt = q_r;
		q_nxt.vec = 1'b0;
		q_nxt.osc_startup_timer = 1'b0;
		unique case (cfg_addr)
			SPS_ADDR_OSC_CFG: q_nxt.rdata = {8'h00, osc_cfg_word};
			SPS_ADDR_WDT_CFG: q_nxt.rdata = {8'h00, wdt_cfg_word};
			SPS_ADDR_BOR_CFG: q_nxt.rdata = {8'h00, bor_cfg_word};
			SPS_ADDR_CSP_CFG: q_nxt.rdata = {8'h00, csp_cfg_word};
			default: q_nxt.rdata = 24'h000000;
		endcase
		if (clk_switch_enable)
			q_nxt.osc = current_osc_select;
		unique case (q_r.st)
			SPS_RUN:
			begin
				if (power_save_instruction_valid)
				begin
					q_nxt.trap = 1'b0;
					q_nxt.st = (power_save_instruction_operand == SPS_OP_IDLE) ?
						SPS_IDLE : SPS_SLEEP;
				end
			end
			SPS_IDLE:
			begin
				if (irq_pending)
				begin
					q_nxt.st = SPS_RUN;
					q_nxt.vec = 1'b1;
					q_nxt.idle_f = 1'b1;
				end
				else if (wdt_enable && wdt_timeout)
				begin
					q_nxt.st = SPS_RUN;
					q_nxt.idle_f = 1'b1;
					q_nxt.watchdog_timeout_flag_f = 1'b1;
				end
			end
			SPS_SLEEP:
			begin
				if (irq_pending || (wdt_enable && wdt_timeout))
				begin
					q_nxt.st = SPS_WAKE_DLY;
					q_nxt.cnt = '0;
					q_nxt.irq_wake = irq_pending;
					q_nxt.sleep_f = 1'b1;
					if (!irq_pending)
						q_nxt.watchdog_timeout_flag_f = 1'b1;
					q_nxt.need_osc = (q_r.osc == SPS_OSC_PRI) ||
						(q_r.osc == SPS_OSC_LP && !lp_osc_keep_on);
					q_nxt.osc_startup_timer = q_nxt.need_osc;
				end
			end
			SPS_WAKE_DLY:
			begin
				q_nxt.cnt = q_r.cnt + 1'b1;
				if (!q_r.need_osc &&
					32'(q_r.cnt) + 1 >= SPS_POWER_ON_DELAY_CYC)
					q_nxt.st = SPS_WAKE_OSC;
				else if (q_r.need_osc && 32'(q_r.cnt) + 1 >=
					SPS_POWER_ON_DELAY_CYC + LOCK_CYC + POWER_UP_TIMER_CYC)
					q_nxt.st = SPS_WAKE_OSC;
			end
			SPS_WAKE_OSC:
			begin
				if (!q_r.need_osc || (osc_startup_done &&
					(!pll_enable || pll_locked) && osc_running))
				begin
					q_nxt.st = SPS_RUN;
					q_nxt.vec = q_r.irq_wake;
				end
				else if (fail_safe_clock_monitor_enable)
				begin
					q_nxt.st = SPS_RUN;
					q_nxt.trap = 1'b1;
					q_nxt.fast_rc_osc = 1'b1;
					q_nxt.osc = SPS_OSC_FRC;
				end
			end
			default: q_nxt.st = SPS_RUN;
		endcase
		if (any_reset)
		begin
			q_nxt.st = SPS_RUN;
			q_nxt.vec = 1'b0;
			q_nxt.trap = 1'b0;
			if (por_pulse)
			begin
				q_nxt.sleep_f = 1'b0;
				q_nxt.idle_f = 1'b0;
				q_nxt.watchdog_timeout_flag_f = 1'b0;
			end
			else
			begin
				q_nxt.sleep_f = 1'b1;
				q_nxt.idle_f = 1'b1;
			end
			if (pwr_reset)
			begin
				q_nxt.osc = cfg_osc;
				q_nxt.fast_rc_osc = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			q_r <= '0;
			q_r.st <= SPS_RUN;
			q_r.osc <= SPS_COSC_RST;
		end
		else
			q_r <= q_nxt;
	end

	assign cpu_clk_en = (q_r.st == SPS_RUN);
	genvar gi;
	generate
		for (gi = 0; gi < PERIPH_N; gi++)
		begin : g_per
			assign periph_clk_en[gi] = (q_r.st == SPS_RUN) ||
				(q_r.st == SPS_IDLE && !periph_idle_stop[gi]);
		end
	endgenerate
	assign osc_en = (q_r.st != SPS_SLEEP) ||
		(lp_osc_keep_on && q_r.osc == SPS_OSC_LP);
	assign low_power_rc_osc_en = (q_r.st == SPS_SLEEP) ? wdt_enable :
		(wdt_enable || fail_safe_clock_monitor_enable || q_r.osc == SPS_OSC_LOW_POWER_RC_OSC);
	assign fail_safe_clock_monitor_active = fail_safe_clock_monitor_enable && (q_r.st != SPS_SLEEP);
	assign bor_active = bor_enable;
	assign lvd_active = lvd_enable;
	assign wake_osc_sel = q_r.osc;
	assign ost_start = q_r.osc_startup_timer;
	assign cpu_vector_irq = q_r.vec;
	assign clk_fail_trap = q_r.trap;
	assign frc_force = q_r.fast_rc_osc;
	assign sleep_flag = q_r.sleep_f;
	assign idle_flag = q_r.idle_f;
	assign watchdog_timeout_flag_flag = q_r.watchdog_timeout_flag_f;
	assign cfg_rdata = q_r.rdata;

endmodule

// >>> testbench/sps_osc_model.sv
`timescale 1ns/1ps
module sps_osc_model
(
	// Clock and control
	input wire logic clk, rst_b, ost_start, osc_dead,
	// Oscillator status
	output logic osc_startup_done, pll_locked, osc_running
);
	logic [3:0] age_r;
	// Crystal ages from each start-up request
	always_ff @(posedge clk)
		if (!rst_b || ost_start)
			age_r <= 4'h0;
		else if (age_r != 4'hF)
			age_r <= age_r + 4'h1;
	assign osc_startup_done = age_r > 4'h3;
	assign pll_locked = age_r > 4'h5;
	// A dead crystal never runs
	assign osc_running = osc_startup_done && !osc_dead;
endmodule

// >>> testbench/sps_ctrl_asserts.sv
`timescale 1ns/1ps
module sps_chk
	import sps_pkg::*;
(
	// Clock, reset, causes
	input logic clk, rst_b, por_pulse, bor_pulse, master_clear_reset_pulse,
	// Requests and events
	input logic power_save_instruction_valid, power_save_instruction_operand, irq_pending, wdt_timeout,
	input logic wdt_enable, bor_enable, lvd_enable,
	input logic [1:0] current_osc_select,
	input logic [23:0] cfg_addr,
	input logic [15:0] osc_cfg_word,
	// Outputs watched
	input logic [23:0] cfg_rdata,
	input logic cpu_clk_en, low_power_rc_osc_en, fail_safe_clock_monitor_active, bor_active, lvd_active,
	input logic ost_start, cpu_vector_irq, sleep_flag, idle_flag, watchdog_timeout_flag_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [1:0] mode_r;
	wire q = !(por_pulse || bor_pulse || master_clear_reset_pulse);
	wire go = power_save_instruction_valid && cpu_clk_en && q;
	wire wk = wdt_timeout && wdt_enable && !irq_pending && q;
	// Tracks run, idle, sleep and waking
	always_ff @(posedge clk)
		if (!rst_b || !q)
			mode_r <= 2'h0;
		else if (go)
			mode_r <= power_save_instruction_operand ? 2'h1 : 2'h2;
		else if (cpu_clk_en)
			mode_r <= 2'h0;
		else if (mode_r == 2'h2 && (irq_pending || wk))
			mode_r <= 2'h3;
	sequence idle_s; mode_r == 2'h1; endsequence
	sleep_gate_a: assert property (mode_r == 2'h2 |-> !cpu_clk_en &&
		!fail_safe_clock_monitor_active && (!wdt_enable || low_power_rc_osc_en)) else $error("sleep gates");
	low_volt_a: assert property (bor_active == bor_enable &&
		lvd_active == lvd_enable) else $error("voltage monitors off");
	idle_irq_a: assert property (idle_s ##0 irq_pending && q |=>
		cpu_clk_en && cpu_vector_irq && idle_flag) else $error("idle irq");
	idle_wdt_a: assert property (idle_s ##0 wk |=>
		cpu_clk_en && idle_flag && watchdog_timeout_flag_flag) else $error("idle wdt");
	wdt_off_a: assert property (idle_s ##0 wdt_timeout && !wdt_enable &&
		!irq_pending && q |=> !cpu_clk_en) else $error("wdt not refused");
	short_wake_a: assert property (mode_r == 2'h2 && irq_pending && q &&
		current_osc_select == SPS_OSC_FRC |-> ##248 !cpu_clk_en ##[1:8]
		cpu_clk_en && sleep_flag) else $error("short wake timing");
	xtal_ost_a: assert property (mode_r == 2'h2 && wk &&
		current_osc_select == SPS_OSC_PRI |-> ##[1:2] ost_start)
		else $error("no start-up timer");
	master_clear_reset_sleep_a: assert property (mode_r == 2'h2 && master_clear_reset_pulse |=>
		sleep_flag) else $error("reset sleep flag");
	por_clear_a: assert property (por_pulse |=> !sleep_flag &&
		!idle_flag && !watchdog_timeout_flag_flag) else $error("flags kept on power-on");
	cfg_read_a: assert property (cfg_addr == SPS_ADDR_OSC_CFG |=>
		cfg_rdata == {8'h00, $past(osc_cfg_word)}) else $error("cfg read");
endmodule
bind sps_ctrl sps_chk u_chk (.*);

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import sps_pkg::*;
	logic clk = 0, rst_b = 0, por_pulse = 0, bor_pulse = 0, master_clear_reset_pulse = 0;
	logic power_save_instruction_valid = 0, power_save_instruction_operand = 0, irq_pending = 0;
	logic wdt_timeout = 0, wdt_enable = 0, fail_safe_clock_monitor_enable = 0, bor_enable = 1;
	logic lvd_enable = 0, clk_switch_enable = 1, lp_osc_keep_on = 0;
	logic pll_enable = 1, osc_dead = 0;
	logic [1:0] current_osc_select = SPS_OSC_FRC, wake_osc_sel;
	logic [7:0] periph_idle_stop = 8'h00, periph_clk_en;
	logic osc_startup_done, pll_locked, osc_running, cpu_clk_en, osc_en;
	logic low_power_rc_osc_en, fail_safe_clock_monitor_active, bor_active, lvd_active, ost_start;
	logic cpu_vector_irq, clk_fail_trap, frc_force;
	logic sleep_flag, idle_flag, watchdog_timeout_flag_flag;
	logic [23:0] cfg_addr = 24'h000000, cfg_rdata;
	logic [15:0] osc_cfg_word = 16'h0312, wdt_cfg_word = 16'h803F;
	logic [15:0] bor_cfg_word = 16'h87B3, csp_cfg_word = 16'h0007;
	int failures = 0, num_checks = 0, cyc = 0;
	sps_ctrl #(.POWER_UP_TIMER_CYC(4), .LOCK_CYC(2)) dut (.*);
	sps_osc_model osc (.*);
	// Clock and cycle ceiling
	initial forever #20 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			end_of_test();
		end
	end
	task tick(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task enter(input logic op);
		power_save_instruction_valid = 1;
		power_save_instruction_operand = op;
		tick();
		power_save_instruction_valid = 0;
		tick();
	endtask
	task wdt_pulse();
		wdt_timeout = 1;
		tick();
		wdt_timeout = 0;
	endtask
	// Cycles until the CPU clock returns
	task wait_cpu(output int n);
		n = 0;
		while (cpu_clk_en !== 1'b1 && n < 3000)
		begin
			tick();
			n++;
		end
	endtask
	task t_cfg();
		logic [23:0] a [5];
		logic [23:0] e [5];
		a = '{SPS_ADDR_OSC_CFG, SPS_ADDR_WDT_CFG, SPS_ADDR_BOR_CFG,
			SPS_ADDR_CSP_CFG, 24'hF80006};
		e = '{{8'h00, osc_cfg_word}, {8'h00, wdt_cfg_word},
			{8'h00, bor_cfg_word}, {8'h00, csp_cfg_word}, 24'h000000};
		for (int i = 0; i < 5; i++)
		begin
			cfg_addr = a[i];
			tick();
			chk(cfg_rdata === e[i], "config read");
		end
	endtask
	task t_idle();
		periph_idle_stop = 8'h5A;
		enter(SPS_OP_IDLE);
		chk(cpu_clk_en === 0 && osc_en === 1, "idle gates");
		chk(periph_clk_en === ~periph_idle_stop, "idle periph");
		wdt_pulse();
		chk(cpu_clk_en === 0, "wdt not refused");
		irq_pending = 1;
		tick();
		irq_pending = 0;
		chk(cpu_clk_en === 1 && cpu_vector_irq === 1, "idle wake");
		chk(idle_flag === 1 && watchdog_timeout_flag_flag === 0, "idle flag");
		wdt_enable = 1;
		enter(SPS_OP_IDLE);
		wdt_pulse();
		chk(cpu_clk_en === 1 && watchdog_timeout_flag_flag === 1, "idle wdt");
	endtask
	task t_sleep();
		int n;
		lvd_enable = 1;
		por_pulse = 1;
		tick();
		por_pulse = 0;
		tick();
		enter(SPS_OP_SLEEP);
		chk(cpu_clk_en === 0 && periph_clk_en === 0 && osc_en === 0, "gates");
		chk(low_power_rc_osc_en === 1 && fail_safe_clock_monitor_active === 0, "sleep rc");
		chk(bor_active === 1 && lvd_active === 1, "sleep monitors");
		irq_pending = 1;
		wait_cpu(n);
		irq_pending = 0;
		chk(n >= SPS_POWER_ON_DELAY_CYC && n <= SPS_POWER_ON_DELAY_CYC + 4, "short wake");
		chk(sleep_flag === 1 && watchdog_timeout_flag_flag === 0, "sleep flag");
		chk(cpu_vector_irq === 1, "sleep vector");
		current_osc_select = SPS_OSC_PRI;
		enter(SPS_OP_SLEEP);
		wdt_pulse();
		wait_cpu(n);
		chk(n >= SPS_POWER_ON_DELAY_CYC + 6 && n < SPS_POWER_ON_DELAY_CYC + 40, "xtal wake");
		chk(watchdog_timeout_flag_flag === 1 && wake_osc_sel === SPS_OSC_PRI, "wdt wake");
		fail_safe_clock_monitor_enable = 1;
		osc_dead = 1;
		enter(SPS_OP_SLEEP);
		wdt_pulse();
		tick(300);
		chk(clk_fail_trap === 1 && frc_force === 1, "clock trap");
		fail_safe_clock_monitor_enable = 0;
		osc_dead = 0;
		current_osc_select = SPS_OSC_FRC;
		por_pulse = 1;
		tick();
		por_pulse = 0;
		chk(frc_force === 0 && sleep_flag === 0 && idle_flag === 0, "por");
		chk(wake_osc_sel === osc_cfg_word[SPS_FOS_LSB+:2], "por osc");
		tick();
		enter(SPS_OP_SLEEP);
		master_clear_reset_pulse = 1;
		tick();
		master_clear_reset_pulse = 0;
		wait_cpu(n);
		chk(sleep_flag === 1 && n < 300, "reset wake");
		current_osc_select = SPS_OSC_LP;
		lp_osc_keep_on = 1;
		enter(SPS_OP_SLEEP);
		chk(osc_en === 1 && cpu_clk_en === 0, "lp kept on");
		irq_pending = 1;
		wait_cpu(n);
		irq_pending = 0;
		chk(n <= SPS_POWER_ON_DELAY_CYC + 4 && ost_start === 0, "lp wake");
	endtask
	task end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Reset, then the scenarios
	initial
	begin
		tick(12);
		rst_b = 1;
		tick();
		t_cfg();
		t_idle();
		t_sleep();
		end_of_test();
	end
endmodule
